// file: rtl/pft_pkg.sv
// Constants and types for the pulse flow totalizer channel.
// Contract
// - A mode field picks dir, single or four-times quadrature decode.
// - Dir mode counts input 1 pulses, up when input 2 low, else down.
// - Single quadrature mode takes count and sign from the pair phase.
// - Four-times mode decodes the pair at four times the resolution.
// - A selectable filter from 10 Hz to 50 kHz rejects faster edges.
// - With the filter off, edges pass without any frequency limit.
// - Rate reads zero when no pulse comes within 0.1, 1 or 10 s.
// - Rate is given per second, per minute or per hour.
// - Low limit flag is set while rate is below the low limit.
// - High limit flag is set while rate is above the high limit.
// - A manual reset command clears the totalizer at once.
// - With channel reset on, a source value above zero clears it.
// - With strobe on, a source value at or below zero holds it.
// - With direction on, a source value above zero reverses counts.
package pft_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LOW = 8'h04;
	localparam logic [7:0] REG_HIGH = 8'h08;
	localparam logic [7:0] REG_RATE = 8'h0c;
	localparam logic [7:0] REG_TOTAL = 8'h10;
	localparam logic [7:0] REG_CMD = 8'h14;
	localparam logic [7:0] REG_ISTAT = 8'h18;
	localparam logic [7:0] REG_IMASK = 8'h1c;
	localparam int CMD_RESET_BIT = 0;
	localparam int IRQ_LOW = 0;
	localparam int IRQ_HIGH = 1;
	localparam int IRQ_ZERO = 2;
	localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
	localparam logic [2:0] IMASK_RST = 3'h0;
	localparam logic [1:0] TB_SEC = 2'h0;
	localparam logic [1:0] TB_MIN = 2'h1;
	localparam logic [15:0] MUL_SEC = 16'h0001;
	localparam logic [15:0] MUL_MIN = 16'h003c;
	localparam logic [15:0] MUL_HOUR = 16'h0e10;
	localparam int unsigned GATE_MS = 1000;
	localparam int unsigned GATE_CYC = CLK_HZ / 1000 * GATE_MS;
	localparam int unsigned ZT0_MS = 100;
	localparam int unsigned ZT1_MS = 1000;
	localparam int unsigned ZT2_MS = 10000;
	localparam int unsigned ZT0_CYC = CLK_HZ / 1000 * ZT0_MS;
	localparam int unsigned ZT1_CYC = CLK_HZ / 1000 * ZT1_MS;
	localparam int unsigned ZT2_CYC = CLK_HZ / 1000 * ZT2_MS;
	localparam logic [3:0] FSEL_OFF = 4'h0;
	localparam logic [3:0] FSEL_MAX = 4'h8;

	// Least stable time of one half period, rounded up to whole cycles.
	function automatic int unsigned hz2cyc(input int unsigned hz);
		return (CLK_HZ + 2 * hz - 1) / (2 * hz);
	endfunction

	localparam logic [7:0][31:0] FILT_CYC_DEF = {
		hz2cyc(50000), hz2cyc(10000), hz2cyc(5000), hz2cyc(1000),
		hz2cyc(100), hz2cyc(50), hz2cyc(25), hz2cyc(10)};

	typedef enum logic [1:0] {
		PFT_DIR = 2'h0,
		PFT_Q1 = 2'h1,
		PFT_Q4 = 2'h2
	} pft_mode_t;

	typedef struct packed {
		logic [18:0] rsv;
		logic dir_en;
		logic strobe_en;
		logic reset_en;
		logic [1:0] tbase;
		logic [1:0] zsel;
		logic [3:0] fsel;
		pft_mode_t mode;
	} pft_cfg_t;

	localparam pft_cfg_t CTRL_RST = pft_cfg_t'(32'h0000_0000);

	typedef struct packed {
		logic inc;
		logic dec;
	} pft_cnt_t;
endpackage

// file: rtl/pft_filter.sv
// Minimum-stable-time filter for one counting input.
`timescale 1ns/1ps
`default_nettype none
module pft_filter
	import pft_pkg::*;
#(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic raw,
	input wire logic [W-1:0] lim,
	output logic flt
);
	logic flt_ff;
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic nxt_flt;
	wire bypass = (lim == '0);
	wire differ = (raw != flt_ff);
	wire done = (cnt_ff + 1'b1 >= lim);

	// A level must hold for lim cycles; shorter pulses are dropped.
	assign nxt_flt = bypass ? raw : (differ && done) ? raw : flt_ff;
	assign nxt_cnt = (bypass || !differ || done) ? '0 : cnt_ff + 1'b1;
	assign flt = flt_ff;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			flt_ff <= 1'b0;
			cnt_ff <= '0;
		end else begin
			flt_ff <= nxt_flt;
			cnt_ff <= nxt_cnt;
		end
	end

	property p_glitch_drop;
		@(posedge clk) disable iff (!nrst)
		(lim > 2 && differ && cnt_ff == '0) ##1 !differ |=> $stable(flt_ff);
	endproperty
	a_glitch_drop: assert property (p_glitch_drop)
		else $error("short pulse passed the filter");

	property p_bypass;
		@(posedge clk) disable iff (!nrst)
		bypass && $stable(lim) |=> flt_ff == $past(raw);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("disabled filter delayed the input");
endmodule
`default_nettype wire

// file: rtl/pft_quad_dec.sv
// Counting-mode decoder turning the two inputs into count pulses.
`timescale 1ns/1ps
`default_nettype none
module pft_quad_dec
	import pft_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_a,
	input wire logic in_b,
	input wire pft_mode_t mode,
	output pft_cnt_t cnt
);
	logic a_ff;
	logic b_ff;
	pft_cnt_t cnt_ff;
	pft_cnt_t nxt_cnt;
	// Gray index of the pair; the forward sequence steps it downward.
	wire [1:0] idx_p = {a_ff, a_ff ^ b_ff};
	wire [1:0] idx_c = {in_a, in_a ^ in_b};
	wire [1:0] step = idx_c - idx_p;
	wire rise_a = in_a && !a_ff;
	// Same sampling serves dir mode and single quadrature: B at A rise.
	wire x1_up = rise_a && !in_b;
	wire x1_dn = rise_a && in_b;
	wire x4_up = (step == 2'h3);
	wire x4_dn = (step == 2'h1);
	wire is_q4 = (mode == PFT_Q4);

	assign nxt_cnt.inc = is_q4 ? x4_up : x1_up;
	assign nxt_cnt.dec = is_q4 ? x4_dn : x1_dn;
	assign cnt = cnt_ff;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			a_ff <= 1'b0;
			b_ff <= 1'b0;
			cnt_ff <= '0;
		end else begin
			a_ff <= in_a;
			b_ff <= in_b;
			cnt_ff <= nxt_cnt;
		end
	end

	property p_dir_sign;
		@(posedge clk) disable iff (!nrst)
		mode == PFT_DIR && rise_a |=> cnt_ff.inc == !$past(in_b)
			&& cnt_ff.dec == $past(in_b);
	endproperty
	a_dir_sign: assert property (p_dir_sign)
		else $error("direction mode counted with wrong sign");

	property p_q1_rate;
		@(posedge clk) disable iff (!nrst)
		mode == PFT_Q1 && !rise_a |=> !cnt_ff.inc && !cnt_ff.dec;
	endproperty
	a_q1_rate: assert property (p_q1_rate)
		else $error("single quadrature counted off an A rise");

	property p_q4_edge;
		@(posedge clk) disable iff (!nrst)
		mode == PFT_Q4 && (step == 2'h1 || step == 2'h3)
			|=> cnt_ff.inc ^ cnt_ff.dec;
	endproperty
	a_q4_edge: assert property (p_q4_edge)
		else $error("four-times mode missed an edge");
endmodule
`default_nettype wire

// file: rtl/pft_top.sv
// Pulse flowmeter channel: filters, decoder, rate, limits, totalizer.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pft_top
	import pft_pkg::*;
#(
	parameter int unsigned GATE_CYCLES = GATE_CYC,
	parameter int unsigned ZT0_CYCLES = ZT0_CYC,
	parameter int unsigned ZT1_CYCLES = ZT1_CYC,
	parameter int unsigned ZT2_CYCLES = ZT2_CYC,
	parameter logic [7:0][31:0] FILT_CYCLES = FILT_CYC_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic cnt_in1,
	input wire logic cnt_in2,
	input wire logic signed [31:0] src_reset_val,
	input wire logic signed [31:0] src_strobe_val,
	input wire logic signed [31:0] src_dir_val,
	output logic [31:0] rate,
	output logic signed [31:0] total,
	output logic low_limit_flag,
	output logic high_limit_flag,
	output logic irq
);
	pft_cfg_t cfg_ff;
	logic [31:0] low_ff;
	logic [31:0] high_ff;
	logic [2:0] istat_ff;
	logic [2:0] imask_ff;
	logic [31:0] rd_data_ff;
	logic [31:0] gate_ff;
	logic [31:0] evcnt_ff;
	logic [31:0] idle_ff;
	logic zero_st_ff;
	logic [31:0] rate_ff;
	logic signed [31:0] total_ff;
	logic lowf_ff;
	logic highf_ff;
	logic irq_ff;
	logic fa;
	logic fb;
	pft_cnt_t cnt;

	// Write decode. Reads return data only in the cycle after the strobe.
	wire wr_ctrl = wr_en && addr == REG_CTRL;
	wire wr_low = wr_en && addr == REG_LOW;
	wire wr_high = wr_en && addr == REG_HIGH;
	wire wr_cmd = wr_en && addr == REG_CMD;
	wire wr_istat = wr_en && addr == REG_ISTAT;
	wire wr_imask = wr_en && addr == REG_IMASK;
	wire man_rst = wr_cmd && wr_data[CMD_RESET_BIT];

	// Select codes above the table act as a disabled filter.
	wire fsel_ok = cfg_ff.fsel != FSEL_OFF && cfg_ff.fsel <= FSEL_MAX;
	wire [2:0] fidx = 3'(cfg_ff.fsel - 4'h1);
	wire [31:0] flim = fsel_ok ? FILT_CYCLES[fidx] : 32'h0000_0000;

	pft_filter #(.W(32)) u_filt_a (
		.clk(clk),
		.nrst(nrst),
		.raw(cnt_in1),
		.lim(flim),
		.flt(fa)
	);

	pft_filter #(.W(32)) u_filt_b (
		.clk(clk),
		.nrst(nrst),
		.raw(cnt_in2),
		.lim(flim),
		.flt(fb)
	);

	pft_quad_dec u_dec (
		.clk(clk),
		.nrst(nrst),
		.in_a(fa),
		.in_b(fb),
		.mode(cfg_ff.mode),
		.cnt(cnt)
	);

	// Rate measurement over a fixed gate, scaled to the time base.
	wire ev = cnt.inc || cnt.dec;
	wire gate_end = (gate_ff == 32'(GATE_CYCLES - 1));
	wire [31:0] ev_total = evcnt_ff + {31'h0, ev};
	wire [15:0] mul = (cfg_ff.tbase == TB_SEC) ? MUL_SEC :
		(cfg_ff.tbase == TB_MIN) ? MUL_MIN : MUL_HOUR;
	wire [47:0] scaled = ev_total * mul;
	wire [31:0] zlim = (cfg_ff.zsel == 2'h0) ? 32'(ZT0_CYCLES) :
		(cfg_ff.zsel == 2'h1) ? 32'(ZT1_CYCLES) : 32'(ZT2_CYCLES);
	wire zero_hit = !ev && (idle_ff == zlim - 32'h1);
	wire [31:0] nxt_rate = gate_end ?
		((zero_st_ff || zero_hit) ? 32'h0 : scaled[31:0]) :
		(zero_hit ? 32'h0 : rate_ff);
	wire [31:0] nxt_idle = ev ? 32'h0 :
		(idle_ff < zlim) ? idle_ff + 32'h1 : idle_ff;
	wire nxt_lowf = rate_ff < low_ff;
	wire nxt_highf = rate_ff > high_ff;

	// Totalizer. Limits never gate accumulation, only flag it.
	wire clr_ch = cfg_ff.reset_en && src_reset_val > 32'sh0;
	wire clr = man_rst || clr_ch;
	wire hold = cfg_ff.strobe_en && src_strobe_val <= 32'sh0;
	wire rev = cfg_ff.dir_en && src_dir_val > 32'sh0;
	wire up = (cnt.inc && !rev) || (cnt.dec && rev);
	wire signed [31:0] delta = !ev ? 32'sh0 :
		up ? 32'sh0000_0001 : 32'shffff_ffff;
	wire signed [31:0] nxt_total = clr ? 32'sh0 :
		hold ? total_ff : total_ff + delta;

	// Sticky events; a set in the clearing cycle survives the clear.
	wire [2:0] iev = {zero_hit, nxt_highf && !highf_ff,
		nxt_lowf && !lowf_ff};
	wire [2:0] iclr = wr_istat ? wr_data[2:0] : 3'h0;
	wire [2:0] nxt_istat = (istat_ff & ~iclr) | iev;
	wire [31:0] rd_mux =
		(addr == REG_CTRL) ? 32'(cfg_ff) :
		(addr == REG_LOW) ? low_ff :
		(addr == REG_HIGH) ? high_ff :
		(addr == REG_RATE) ? rate_ff :
		(addr == REG_TOTAL) ? total_ff :
		(addr == REG_ISTAT) ? {29'h0, istat_ff} :
		(addr == REG_IMASK) ? {29'h0, imask_ff} : 32'h0;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_ff <= CTRL_RST;
			low_ff <= LIMIT_RST;
			high_ff <= LIMIT_RST;
			imask_ff <= IMASK_RST;
		end else begin
			if (wr_ctrl)
				cfg_ff <= pft_cfg_t'(wr_data);
			if (wr_low)
				low_ff <= wr_data;
			if (wr_high)
				high_ff <= wr_data;
			if (wr_imask)
				imask_ff <= wr_data[2:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			gate_ff <= 32'h0;
			evcnt_ff <= 32'h0;
			idle_ff <= 32'h0;
			zero_st_ff <= 1'b0;
			rate_ff <= 32'h0;
		end else begin
			gate_ff <= gate_end ? 32'h0 : gate_ff + 32'h1;
			evcnt_ff <= gate_end ? 32'h0 : ev_total;
			idle_ff <= nxt_idle;
			zero_st_ff <= ev ? 1'b0 : (zero_st_ff || zero_hit);
			rate_ff <= nxt_rate;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			total_ff <= 32'sh0;
			lowf_ff <= 1'b0;
			highf_ff <= 1'b0;
			istat_ff <= 3'h0;
			irq_ff <= 1'b0;
			rd_data_ff <= 32'h0;
		end else begin
			total_ff <= nxt_total;
			lowf_ff <= nxt_lowf;
			highf_ff <= nxt_highf;
			istat_ff <= nxt_istat;
			irq_ff <= |(nxt_istat & imask_ff);
			rd_data_ff <= rd_en ? rd_mux : 32'h0;
		end
	end

	assign rd_data = rd_data_ff;
	assign rate = rate_ff;
	assign total = total_ff;
	assign low_limit_flag = lowf_ff;
	assign high_limit_flag = highf_ff;
	assign irq = irq_ff;

	property p_man_rst;
		@(posedge clk) disable iff (!nrst)
		man_rst |=> total_ff == 32'sh0;
	endproperty
	a_man_rst: assert property (p_man_rst)
		else $error("manual reset left the totalizer set");

	property p_ch_rst;
		@(posedge clk) disable iff (!nrst)
		cfg_ff.reset_en && src_reset_val > 32'sh0 |=> total_ff == 32'sh0;
	endproperty
	a_ch_rst: assert property (p_ch_rst)
		else $error("channel reset did not clear the totalizer");

	property p_strobe_hold;
		@(posedge clk) disable iff (!nrst)
		hold && !clr |=> total_ff == $past(total_ff);
	endproperty
	a_strobe_hold: assert property (p_strobe_hold)
		else $error("totalizer moved while strobe held it");

	property p_dir_rev;
		@(posedge clk) disable iff (!nrst)
		cnt.inc && rev && !hold && !clr
			|=> total_ff == $past(total_ff) - 32'sh1;
	endproperty
	a_dir_rev: assert property (p_dir_rev)
		else $error("reversed direction counted up");

	sequence s_zero_wait;
		zero_hit ##1 !ev [*2];
	endsequence
	property p_zero;
		@(posedge clk) disable iff (!nrst)
		s_zero_wait |-> rate_ff == 32'h0;
	endproperty
	a_zero: assert property (p_zero)
		else $error("rate not forced to zero after timeout");

	property p_scale;
		@(posedge clk) disable iff (!nrst)
		gate_end && !zero_st_ff && !zero_hit |=> rate_ff ==
			32'($past(ev_total) * $past(mul));
	endproperty
	a_scale: assert property (p_scale)
		else $error("rate not scaled to the time base");

	property p_low;
		@(posedge clk) disable iff (!nrst)
		rate_ff < low_ff && $stable(low_ff) ##1 $stable(rate_ff)
			|-> lowf_ff;
	endproperty
	a_low: assert property (p_low)
		else $error("low limit flag missing");

	property p_high;
		@(posedge clk) disable iff (!nrst)
		rate_ff > high_ff && $stable(high_ff) ##1 $stable(rate_ff)
			|-> highf_ff;
	endproperty
	a_high: assert property (p_high)
		else $error("high limit flag missing");

	property p_set_wins;
		@(posedge clk) disable iff (!nrst)
		zero_hit && wr_istat && wr_data[IRQ_ZERO] |=> istat_ff[IRQ_ZERO];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("timeout event lost to a status clear");

	property p_count_up;
		@(posedge clk) disable iff (!nrst)
		cnt.inc && !rev && !hold && !clr
			|=> total_ff == $past(total_ff) + 32'sh1;
	endproperty
	a_count_up: assert property (p_count_up)
		else $error("forward count did not raise the totalizer");

	// Limits only flag the rate; every count must still reach the total.
	property p_acc_limits;
		@(posedge clk) disable iff (!nrst)
		ev && !hold && !clr |=> total_ff != $past(total_ff);
	endproperty
	a_acc_limits: assert property (p_acc_limits)
		else $error("a count was lost from the totalizer");

	// A held total must not freeze the rate path, or rate would lie.
	property p_rate_runs;
		@(posedge clk) disable iff (!nrst)
		hold && ev && !gate_end
			|=> evcnt_ff == $past(evcnt_ff) + 32'h1;
	endproperty
	a_rate_runs: assert property (p_rate_runs)
		else $error("strobe hold stopped the rate measurement");

	property p_zero_stay;
		@(posedge clk) disable iff (!nrst)
		zero_st_ff && !ev |=> rate_ff == 32'h0;
	endproperty
	a_zero_stay: assert property (p_zero_stay)
		else $error("rate left zero without a new pulse");

	property p_irq_level;
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> irq_ff == |(istat_ff & $past(imask_ff));
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt does not follow unmasked status");

	property p_rd_idle;
		@(posedge clk) disable iff (!nrst)
		!rd_en |=> rd_data_ff == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data stood outside its cycle");
endmodule
`default_nettype wire

// file: dv/pft_sensor.sv
// Flow sensor model: direction pulses or quadrature steps.
`timescale 1ns/1ps
`default_nettype none
module pft_sensor (
	input wire logic clk,
	input wire logic go,
	input wire logic up,
	input wire logic quad,
	input wire logic [7:0] half,
	input wire logic [15:0] steps,
	output logic a,
	output logic b,
	output logic busy
);
	logic [1:0] ph_ff = 2'h0;
	logic [15:0] rem_ff = 16'h0;
	logic [7:0] tmr_ff = 8'h0;
	always_ff @(posedge clk) begin
		if (go) begin
			rem_ff <= steps;
			tmr_ff <= half;
		end else if (rem_ff != 16'h0) begin
			if (tmr_ff == 8'h1) begin
				ph_ff <= up ? ph_ff + 2'h1 : ph_ff - 2'h1;
				rem_ff <= rem_ff - 16'h1;
				tmr_ff <= half;
			end else begin
				tmr_ff <= tmr_ff - 8'h1;
			end
		end
	end
	// A leads B for forward flow; the phase is kept across runs.
	assign a = quad ? ph_ff[1] ^ ph_ff[0] : ph_ff[0];
	assign b = quad ? ph_ff[1] : ~up;
	assign busy = rem_ff != 16'h0;
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the pulse flow totalizer channel.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import pft_pkg::*;
;
	localparam logic [7:0][31:0] FC = {{7{32'h2}}, 32'h8};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic go = 1'b0;
	logic up = 1'b1;
	logic quad = 1'b0;
	logic [7:0] addr = 8'h0;
	logic [7:0] half = 8'h4;
	logic [15:0] steps = 16'h0;
	logic [31:0] wr_data = 32'h0;
	logic signed [31:0] s_rst = 32'sh0;
	logic signed [31:0] s_stb = 32'sh0;
	logic signed [31:0] s_dir = 32'sh0;
	logic signed [31:0] et = 32'sh0;
	logic [31:0] rd_data, rate, v;
	logic signed [31:0] total;
	logic low_flag, high_flag, irq, a, b, busy;
	int error_cnt = 0;
	int checked = 0;
	always #10 clk = ~clk;
	pft_top #(.GATE_CYCLES(100), .ZT0_CYCLES(50), .ZT1_CYCLES(200),
		.ZT2_CYCLES(400), .FILT_CYCLES(FC)) pft_top_i (.clk(clk),
		.nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .cnt_in1(a), .cnt_in2(b),
		.src_reset_val(s_rst), .src_strobe_val(s_stb),
		.src_dir_val(s_dir), .rate(rate), .total(total),
		.low_limit_flag(low_flag), .high_limit_flag(high_flag),
		.irq(irq));
	pft_sensor pft_sensor_i (.clk(clk), .go(go), .up(up), .quad(quad),
		.half(half), .steps(steps), .a(a), .b(b), .busy(busy));
	task automatic close_out;
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tmo;
		error_cnt++;
		close_out();
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		addr <= ad;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] q);
		@(posedge clk);
		addr <= ad;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		q = rd_data;
	endtask
	task automatic start(input logic u, input logic [7:0] h,
		input logic [15:0] s);
		@(posedge clk);
		up <= u;
		half <= h;
		steps <= s;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	// Sixteen cycles cover the filter and the three pipeline stages.
	task automatic fin;
		int i;
		i = 0;
		#1;
		while (busy && i < 20000) begin
			cyc(1);
			i++;
		end
		if (busy)
			tmo();
		cyc(16);
	endtask
	task automatic run(input logic u, input logic [7:0] h,
		input logic [15:0] s);
		start(u, h, s);
		fin();
	endtask
	task automatic t_reset;
		chk("total", 32'h0, total);
		chk("rate", 32'h0, rate);
		chk("flags", 32'h0, {low_flag, high_flag, irq});
		rd(REG_CTRL, v);
		chk("ctrl", 32'h0, v);
		rd(REG_IMASK, v);
		chk("imask", 32'h0, v);
		rd(8'h20, v);
		chk("unmapped", 32'h0, v);
		cyc(1);
		chk("rd_idle", 32'h0, rd_data);
		wr(REG_TOTAL, 32'h5);
		rd(REG_TOTAL, v);
		chk("total_ro", 32'h0, v);
	endtask
	task automatic t_quad;
		wr(REG_CTRL, 32'h1);
		quad <= 1'b1;
		run(1'b1, 8'h4, 16'h8);
		chk("q1_up", 32'h2, total);
		run(1'b0, 8'h4, 16'h8);
		chk("q1_dn", 32'h0, total);
		wr(REG_CTRL, 32'h2);
		run(1'b1, 8'h4, 16'h8);
		chk("q4_up", 32'h8, total);
		run(1'b0, 8'h4, 16'h4);
		chk("q4_dn", 32'h4, total);
		wr(REG_CTRL, 32'h0);
		quad <= 1'b0;
		et = 32'sh4;
	endtask
	task automatic t_dir;
		run(1'b1, 8'h4, 16'h14);
		chk("dir_up", et + 32'sha, total);
		run(1'b0, 8'h4, 16'h8);
		et = et + 32'sh6;
		rd(REG_TOTAL, v);
		chk("dir_dn", et, v);
	endtask
	task automatic t_filter;
		wr(REG_CTRL, 32'h4);
		run(1'b1, 8'h3, 16'h8);
		chk("flt_drop", et, total);
		run(1'b1, 8'hc, 16'h8);
		et = et + 32'sh4;
		chk("flt_pass", et, total);
		wr(REG_CTRL, 32'h0);
		run(1'b1, 8'h2, 16'h8);
		et = et + 32'sh4;
		chk("flt_off", et, total);
	endtask
	task automatic t_rate;
		int i;
		wr(REG_LOW, 32'h14);
		wr(REG_HIGH, 32'h5);
		start(1'b1, 8'h5, 16'd1600);
		cyc(260);
		chk("rate_s", 32'ha, rate);
		chk("low_set", 32'h1, low_flag);
		chk("high_set", 32'h1, high_flag);
		wr(REG_LOW, 32'h5);
		wr(REG_HIGH, 32'h14);
		cyc(4);
		chk("lim_clr", 32'h0, {low_flag, high_flag});
		wr(REG_CTRL, 32'h100);
		cyc(250);
		chk("rate_m", 32'd600, rate);
		wr(REG_CTRL, 32'h200);
		cyc(250);
		chk("rate_h", 32'd36000, rate);
		fin();
		et = et + 32'sd800;
		chk("tot_lim", et, total);
		i = 0;
		while (rate !== 32'h0 && i < 64) begin
			cyc(1);
			i++;
		end
		if (rate !== 32'h0)
			tmo();
		chk("zero_t", 32'h0, rate);
		// The last count lands 18 cycles before the wait, leaving 32 of 50.
		chk("zero_time", 32'd32, i);
		rd(REG_ISTAT, v);
		chk("istat", 32'h7, v);
		chk("irq_mask", 32'h0, irq);
		wr(REG_IMASK, 32'h4);
		cyc(2);
		chk("irq_on", 32'h1, irq);
		wr(REG_ISTAT, 32'h4);
		cyc(2);
		chk("irq_off", 32'h0, irq);
		rd(REG_ISTAT, v);
		chk("istat_w1c", 32'h3, v);
		wr(REG_CTRL, 32'h40);
		run(1'b1, 8'h4, 16'h2);
		cyc(150);
		rd(REG_ISTAT, v);
		chk("zt1_wait", 32'h3, v);
		cyc(40);
		rd(REG_ISTAT, v);
		chk("zt1_hit", 32'h7, v);
	endtask
	task automatic t_ctl;
		wr(REG_CMD, 32'h1);
		cyc(2);
		chk("man_rst", 32'h0, total);
		wr(REG_CTRL, 32'h400);
		run(1'b1, 8'h4, 16'h8);
		chk("crst_0", 32'h4, total);
		@(posedge clk);
		s_rst <= 32'sh1;
		cyc(4);
		chk("crst_1", 32'h0, total);
		@(posedge clk);
		s_rst <= 32'sh0;
		wr(REG_CTRL, 32'h800);
		run(1'b1, 8'h4, 16'h8);
		chk("stb_0", 32'h0, total);
		@(posedge clk);
		s_stb <= 32'sh1;
		run(1'b1, 8'h4, 16'h8);
		chk("stb_1", 32'h4, total);
		wr(REG_CTRL, 32'h1000);
		run(1'b1, 8'h4, 16'h8);
		chk("dir_0", 32'h8, total);
		@(posedge clk);
		s_dir <= 32'sh1;
		run(1'b1, 8'h4, 16'hc);
		chk("dir_1", 32'h2, total);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		cyc(1);
		t_reset();
		t_quad();
		t_dir();
		t_filter();
		t_rate();
		t_ctl();
		close_out();
	end
endmodule
`default_nettype wire
